// ---- hw/gsa_regfile.sv ----
// Sixteen-entry 64-bit general-purpose register file with sub-views
//
// Overview of operation
// RL1: Without prefix, byte codes pick four lower or four upper legacy bytes.
// RL2: With prefix, byte codes pick lower, index/pointer low or extension lows.
// RL3: Word codes reach eight legacy words; prefix adds extension low words.
// RL4: Dword codes reach eight legacy dwords; prefix adds extension dwords.
// RL5: Quadword views exist only when the extension prefix is present.
// RL6: Never combine an upper legacy byte with a new byte register.
// RL7: Lower legacy bytes and new byte registers may be used together.
// RL8: With prefix, upper-byte codes select index and pointer low bytes.
// RL9: A 64-bit result overwrites the whole destination.
// RL10: A 32-bit result is written zero-extended to 64 bits.
// RL11: Byte and word results keep the upper 56 or 48 bits.
// RL12: Upper 32 bits need not survive a switch out of 64-bit mode.
// RL13: Sixteen registers in 64-bit mode, default operand size 32 bits.
// RL14: Per-byte write enables from size and view merge partial writes.
`timescale 1ns/100ps
`include "gsa_map.svh"
module gsa_regfile #(
  parameter int NUM_REGS = `GSA_NUM_REGS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic mode64,
  input wire logic extPrefix,
  input wire logic wideSize,
  input wire logic [3:0] rdCodeA,
  input wire logic [3:0] rdCodeB,
  input wire logic [1:0] rdSize,
  input wire gsa_pkg::gsa_wreq_t wreq,
  output logic [63:0] rdDataA,
  output logic [63:0] rdDataB,
  output logic rdLegal,
  output logic wrLegal,
  output gsa_pkg::gsa_size_t effSize
);
  // ****************************************************************
  // View decode
  // ****************************************************************
  function automatic gsa_pkg::gsa_view_t decodeView(
    input logic [3:0] code,
    input gsa_pkg::gsa_size_t size,
    input logic pfx
  );
    gsa_pkg::gsa_view_t v;
    v = '0;
    v.legal = 1'b1;
    v.index = code;
    if (!pfx && code[3])
    begin
      v.legal = 1'b0; // RL3 RL4 RL1
    end
    if (size == gsa_pkg::GSA_SZ_QWORD && !pfx)
    begin
      v.legal = 1'b0; // RL5
    end
    if (size == gsa_pkg::GSA_SZ_BYTE)
    begin
      if (!pfx && code[2])
      begin
        v.upperByte = 1'b1; // RL1
        v.index = {2'h0, code[1:0]};
      end
      else if (pfx && code >= 4'(`GSA_UPPER_BYTE_FIRST))
      begin
        v.newByte = 1'b1; // RL2 RL8
      end
    end
    return v;
  endfunction

  gsa_pkg::gsa_size_t rdSz;
  gsa_pkg::gsa_view_t viewA, viewB, viewW;
  gsa_pkg::gsa_regs_t st_reg, st_next;
  logic [7:0] byteEn;
  logic [63:0] wrMerged;

  always_comb
  begin
    // Default 32-bit size unless the prefix widens it
    rdSz = gsa_pkg::gsa_size_t'(rdSize);
    if (rdSz == gsa_pkg::GSA_SZ_QWORD && !wideSize)
    begin
      rdSz = gsa_pkg::GSA_SZ_DWORD; // RL13
    end
  end

  assign effSize = rdSz;

  always_comb
  begin
    viewA = decodeView(rdCodeA, rdSz, extPrefix);
    viewB = decodeView(rdCodeB, rdSz, extPrefix);
    viewW = decodeView(wreq.opnd.code, wreq.opnd.size, extPrefix);
  end

  // ****************************************************************
  // Write enables and merge
  // ****************************************************************
  always_comb
  begin
    byteEn = 8'h00;
    wrMerged = st_reg.regs[viewW.index];
    case (wreq.opnd.size)
      gsa_pkg::GSA_SZ_BYTE:
      begin
        if (viewW.upperByte)
        begin
          byteEn = 8'h02; // RL14
          wrMerged[15:8] = wreq.data[7:0]; // RL11
        end
        else
        begin
          byteEn = 8'h01; // RL14
          wrMerged[7:0] = wreq.data[7:0]; // RL11
        end
      end
      gsa_pkg::GSA_SZ_WORD:
      begin
        byteEn = 8'h03; // RL14
        wrMerged[15:0] = wreq.data[15:0]; // RL11
      end
      gsa_pkg::GSA_SZ_DWORD:
      begin
        byteEn = 8'hFF;
        wrMerged = {32'h00000000, wreq.data[31:0]}; // RL10
      end
      gsa_pkg::GSA_SZ_QWORD:
      begin
        byteEn = 8'hFF;
        wrMerged = wreq.data; // RL9
      end
      default:
      begin
        byteEn = 8'h00;
      end
    endcase
  end

  assign wrLegal = viewW.legal;

  // ****************************************************************
  // State update
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;
    case (st_reg.mode)
      gsa_pkg::GSA_ST_RESET:
      begin
        st_next.mode = mode64 ? gsa_pkg::GSA_ST_MODE64
                              : gsa_pkg::GSA_ST_MODE32;
      end
      gsa_pkg::GSA_ST_MODE64:
      begin
        if (!mode64)
        begin
          // Clearing is one legal choice for undefined upper halves
          for (int i = 0; i < NUM_REGS; i++)
          begin
            st_next.regs[i][63:32] = 32'h00000000; // RL12
          end
          st_next.mode = gsa_pkg::GSA_ST_MODE32;
        end
      end
      gsa_pkg::GSA_ST_MODE32:
      begin
        if (mode64)
        begin
          st_next.mode = gsa_pkg::GSA_ST_MODE64;
        end
      end
      default:
      begin
        st_next.mode = gsa_pkg::GSA_ST_RESET;
      end
    endcase
    if (wreq.valid && viewW.legal && mode64 && byteEn != 8'h00)
    begin
      st_next.regs[viewW.index] = wrMerged; // RL14
    end
    // Upper legacy bytes and new bytes never mix in one access
    st_next.rdLegal = viewA.legal && viewB.legal
      && !((viewA.upperByte && viewB.newByte)
        || (viewB.upperByte && viewA.newByte)); // RL6 RL7
    st_next.rdA = st_reg.regs[viewA.index];
    st_next.rdB = st_reg.regs[viewB.index];
    case (rdSz)
      gsa_pkg::GSA_SZ_BYTE:
      begin
        st_next.rdA = {56'h0, viewA.upperByte
          ? st_reg.regs[viewA.index][15:8]
          : st_reg.regs[viewA.index][7:0]}; // RL1 RL2
        st_next.rdB = {56'h0, viewB.upperByte
          ? st_reg.regs[viewB.index][15:8]
          : st_reg.regs[viewB.index][7:0]};
      end
      gsa_pkg::GSA_SZ_WORD:
      begin
        st_next.rdA = {48'h0, st_reg.regs[viewA.index][15:0]}; // RL3
        st_next.rdB = {48'h0, st_reg.regs[viewB.index][15:0]};
      end
      gsa_pkg::GSA_SZ_DWORD:
      begin
        st_next.rdA = {32'h0, st_reg.regs[viewA.index][31:0]}; // RL4
        st_next.rdB = {32'h0, st_reg.regs[viewB.index][31:0]};
      end
      default:
      begin
        st_next.rdA = st_reg.regs[viewA.index]; // RL5
        st_next.rdB = st_reg.regs[viewB.index];
      end
    endcase
    if (!st_next.rdLegal)
    begin
      st_next.rdA = 64'h0;
      st_next.rdB = 64'h0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_reg <= '0;
      st_reg.mode <= gsa_pkg::GSA_ST_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rdDataA = st_reg.rdA;
  assign rdDataB = st_reg.rdB;
  assign rdLegal = st_reg.rdLegal;
endmodule // gsa_regfile

// ---- hw/gsa_map.svh ----
// Constants for the general-purpose register file access block
`ifndef GSA_MAP_SVH
`define GSA_MAP_SVH
`define GSA_NUM_REGS 16
`define GSA_DATA_W 64
`define GSA_IDX_W 4
`define GSA_BYTE_W 8
`define GSA_WORD_W 16
`define GSA_DWORD_W 32
`define GSA_UPPER_BYTE_FIRST 4
`define GSA_RESET_VALUE 64'h0000000000000000
`endif

// ---- hw/gsa_pkg.sv ----
// Types for the general-purpose register file access block
package gsa_pkg;
  typedef enum logic [1:0] {
    GSA_SZ_BYTE = 2'h0,
    GSA_SZ_WORD = 2'h1,
    GSA_SZ_DWORD = 2'h2,
    GSA_SZ_QWORD = 2'h3
  } gsa_size_t;

  // One operand reference as decoded from an instruction
  typedef struct packed {
    logic [3:0] code;
    gsa_size_t size;
  } gsa_opnd_t;

  // Physical view after prefix handling
  typedef struct packed {
    logic [3:0] index;
    logic upperByte;
    logic newByte;
    logic legal;
  } gsa_view_t;

  typedef struct packed {
    logic valid;
    gsa_opnd_t opnd;
    logic [63:0] data;
  } gsa_wreq_t;

  typedef enum logic [2:0] {
    GSA_ST_MODE64 = 3'h1,
    GSA_ST_MODE32 = 3'h2,
    GSA_ST_RESET = 3'h4
  } gsa_state_t;

  typedef struct packed {
    logic [15:0][63:0] regs;
    gsa_state_t mode;
    logic [63:0] rdA;
    logic [63:0] rdB;
    logic rdLegal;
  } gsa_regs_t;
endpackage

// ---- testbench/gsa_regfile_properties.sv ----
// Checker of view legality and width rules for the register file
`timescale 1ns/100ps
module gsa_regfile_properties #(parameter int NUM_REGS = 16) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic mode64,
  input wire logic extPrefix,
  input wire logic wideSize,
  input wire logic [3:0] rdCodeA,
  input wire logic [3:0] rdCodeB,
  input wire logic [1:0] rdSize,
  input wire gsa_pkg::gsa_wreq_t wreq,
  input wire logic [63:0] rdDataA,
  input wire logic [63:0] rdDataB,
  input wire logic rdLegal,
  input wire logic wrLegal,
  input wire gsa_pkg::gsa_size_t effSize
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_qw;
    wreq.valid && wrLegal && mode64 && wreq.opnd.size == 2'h3;
  endsequence
  sequence s_qr;
    extPrefix && wideSize && mode64 && rdSize == 2'h3 &&
      rdCodeA == $past(wreq.opnd.code);
  endsequence
  a_reset_clear: assert property (disable iff (1'h0)
    rst |=> !rdLegal && rdDataA == 64'h0) else $error("reset kept data");
  a_nopfx_refused: assert property (
    !extPrefix && (rdCodeA[3] || (rdSize == 2'h3 && wideSize))
      |=> !rdLegal)
    else $error("bad read taken");
  a_pfx_legal: assert property (
    extPrefix && wideSize && mode64 |=> rdLegal) else $error("read refused");
  a_refused_zero: assert property (
    !rdLegal |-> rdDataA == 64'h0 && rdDataB == 64'h0) else $error("leak");
  a_byte_ext: assert property (
    rdSize == 2'h0 |=> rdDataA[63:8] == 56'h0) else $error("byte too wide");
  a_eff_size: assert property (
    effSize == (rdSize == 2'h3 && !wideSize ? 2'h2 : rdSize))
    else $error("bad size");
  a_wr_refused: assert property (
    !extPrefix && (wreq.opnd.code[3] || wreq.opnd.size == 2'h3) |-> !wrLegal)
    else $error("bad write taken");
  a_qword_echo: assert property (
    s_qw ##1 s_qr |=> rdDataA == $past(wreq.data, 2)) else $error("qword");
endmodule // gsa_regfile_properties
bind gsa_regfile gsa_regfile_properties #(.NUM_REGS(NUM_REGS)) u_props (
  .mclk(mclk), .rst(rst), .mode64(mode64), .extPrefix(extPrefix),
  .wideSize(wideSize), .rdCodeA(rdCodeA), .rdCodeB(rdCodeB),
  .rdSize(rdSize), .wreq(wreq), .rdDataA(rdDataA), .rdDataB(rdDataB),
  .rdLegal(rdLegal), .wrLegal(wrLegal), .effSize(effSize));

// ---- testbench/gsa_exec_model.sv ----
// Execute-stage model that issues write requests
`timescale 1ns/100ps
module gsa_exec_model (
  input wire logic [70:0] req,
  output gsa_pkg::gsa_wreq_t wreq
);
  // Result, destination and size leave together in one request
  assign wreq = req;
endmodule // gsa_exec_model

// ---- testbench/tb_gsa_regfile.sv ----
// Self-checking bench for the register file access block
`timescale 1ns/100ps
module tb_gsa_regfile;
  typedef struct {int due; logic [128:0] v;} gsa_note_t;
  gsa_note_t notes[$], n;
  logic mclk = 1'h0, rst = 1'h1, mode64 = 1'h1, rdLegal;
  logic extPrefix = 1'h0, wideSize = 1'h0;
  logic [3:0] rdCodeA = 4'h0, rdCodeB = 4'h0;
  logic [1:0] rdSize = 2'h0;
  logic [70:0] wq = '0;
  logic [63:0] rdDataA, rdDataB, mdl [16];
  gsa_pkg::gsa_wreq_t wreq;
  int errors = 0, comparisons = 0, cyc = 0;
  always #2.5 mclk = ~mclk;
  gsa_exec_model u_exec (.req(wq), .wreq(wreq));
  gsa_regfile u_dut (.mclk(mclk), .rst(rst), .mode64(mode64),
    .extPrefix(extPrefix), .wideSize(wideSize), .rdCodeA(rdCodeA),
    .rdCodeB(rdCodeB), .rdSize(rdSize), .wreq(wreq), .rdDataA(rdDataA),
    .rdDataB(rdDataB), .rdLegal(rdLegal), .wrLegal(), .effSize());
  function automatic logic [64:0] view(logic [3:0] c, logic [1:0] s, logic p);
    // Without the widening prefix a quadword read falls back to a dword
    if (!p && s == 2'h3)
      s = 2'h2;
    if (!p && c[3])
      return '0;
    if (!p && s == 2'h0 && c[2])
      return {1'h1, 64'(mdl[c[1:0]][15:8])};
    case (s)
      2'h0: return {1'h1, 64'(mdl[c][7:0])};
      2'h1: return {1'h1, 64'(mdl[c][15:0])};
      2'h2: return {1'h1, 64'(mdl[c][31:0])};
      default: return {1'h1, mdl[c]};
    endcase
  endfunction
  task automatic rd(logic [3:0] a, logic [3:0] b, logic [1:0] s, logic p);
    logic [64:0] va, vb;
    va = view(a, s, p);
    vb = view(b, s, p);
    wq[70] = 1'h0;
    {rdCodeA, rdCodeB, rdSize, extPrefix, wideSize} = {a, b, s, p, p};
    notes.push_back('{cyc + 1, (va[64] & vb[64]) ? {va, vb[63:0]} : '0});
    @(posedge mclk);
    #1;
  endtask
  task automatic wr(logic [3:0] c, logic [1:0] s, logic p, logic [63:0] d);
    {wq, extPrefix, wideSize} = {1'h1, c, s, d, p, p};
    // Writes outside 64-bit mode or to refused views leave the file alone
    if (mode64 && (p || !(c[3] || s == 2'h3)))
      case (s)
        2'h0: if (!p && c[2]) mdl[c[1:0]][15:8] = d[7:0];
              else mdl[c][7:0] = d[7:0];
        2'h1: mdl[c][15:0] = d[15:0];
        2'h2: mdl[c] = {32'h0, d[31:0]};
        default: mdl[c] = d;
      endcase
    @(posedge mclk);
    #1;
  endtask
  task automatic sweep();
    for (int k = 0; k < 128; k++)
      rd(4'(k), 4'($urandom), 2'(k >> 4), 1'(k >> 6));
  endtask
  task automatic close_out();
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(negedge mclk)
    if (notes.size() > 0 && notes[0].due == cyc)
    begin
      n = notes.pop_front();
      comparisons++;
      if ({rdLegal, rdDataA, rdDataB} !== n.v)
      begin
        errors++;
        $display("Error read view exp %h seen %h", n.v,
          {rdLegal, rdDataA, rdDataB});
      end
    end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      errors++;
      close_out();
    end
  end
  initial
  begin
    void'($urandom(32'hEE32E5C2));
    foreach (mdl[i])
      mdl[i] = '0;
    repeat (16) @(posedge mclk);
    #1;
    rst = 1'h0;
    sweep();
    for (int i = 0; i < 16; i++)
      wr(4'(i), 2'h3, 1'h1, {$urandom, $urandom});
    wr(4'h9, 2'h2, 1'h1, '1);
    wr(4'h2, 2'h1, 1'h1, '0);
    wr(4'h5, 2'h0, 1'h0, 64'hA5A5A5A5A5A5A5A5);
    wr(4'h6, 2'h0, 1'h1, 64'h5A5A5A5A5A5A5A5A);
    wr(4'hC, 2'h1, 1'h0, '1);
    wr(4'h3, 2'h3, 1'h0, '1);
    sweep();
    mode64 = 1'h0;
    repeat (3) @(posedge mclk);
    #1;
    wr(4'h1, 2'h3, 1'h1, '1);
    wq[70] = 1'h0;
    mode64 = 1'h1;
    foreach (mdl[i])
      mdl[i][63:32] = '0;
    repeat (3) @(posedge mclk);
    #1;
    sweep();
    // Let the last read note reach the checker before the verdict
    repeat (2) @(posedge mclk);
    close_out();
  end
endmodule // tb_gsa_regfile
